// *** include/nfw_regs.vh ***
/*
 * constants for the flash control-pin front end: bus operation codes,
 * timing figures in ns for deriving cycle counts, status reset value.
 * assumes ref_clk at 25 MHz and includers that use the names below.
 */
// Overview of operation
// RULE1: host never drives output enable and write enable low together.
// RULE2: chip select low selects; output enable low reads, write enable low writes.
// RULE3: control pins decode to reset, standby, deep sleep, output disable, read, write.
// RULE4: a write ends when chip select or write enable rises, whichever first.
// RULE5: effective write pulse, later fall to earlier rise, lasts at least 40 ns.
// RULE6: before sync burst after write, 15 ns to clock and chip select toggle.
// RULE7: status read after status-changing command waits 20 ns from write enable high.
// RULE8: add 10 ns write-to-read when read config or lock state changes.
// RULE9: read data after write valid no sooner than access time plus 30 ns.
// RULE10: sync mode with running clock, write enable within 27 ns of latch event.
// RULE11: host may stop the clock during a write cycle.
// RULE12: host keeps program supply and write protect valid until success confirmed.
// RULE13: main block erase typically 0.9 s, at most 4 s.
// RULE14: reset while idle completes within 100 ns; the code counts 3 cycles of 40 ns, 120 ns.
// RULE15: reset during program or erase completes abort within 25 us.
// RULE16: host waits 150 ns after reset release before write enable low.
// RULE17: host holds sleep pin through deep sleep; low current after 40 us.
// RULE18: after deep sleep exit, host waits 75 us before chip select low.
// RULE19: sleep pin active low when polarity bit is 0.
// RULE20: wait output deasserted in async reads; low-true when polarity bit 0.
// RULE21: deep sleep needs enable bit 1 and sleep pin asserted, any order.
// RULE22: deep sleep entry resets status to 0080h, keeps config and locks.
// RULE23: write address and data captured on first rise of write enable or select.
// RULE24: host keeps select, output enable, write enable high during its reset.
`ifndef NFW_REGS_VH
`define NFW_REGS_VH

`define NFW_OP_RESET       3'h0
`define NFW_OP_STANDBY     3'h1
`define NFW_OP_SLEEP       3'h2
`define NFW_OP_OUT_DIS     3'h3
`define NFW_OP_READ        3'h4
`define NFW_OP_WRITE       3'h5
`define NFW_OP_CONFLICT    3'h6

`define NFW_CLK_NS         40
`define NFW_RST_IDLE_NS    100
`define NFW_RST_BUSY_NS    25000
`define NFW_WR_READ_NS     30
`define NFW_ACCESS_NS      96
`define NFW_SLEEP_LOW_NS   40000
`define NFW_ERASE_TYP_NS   900000000
`define NFW_ERASE_MAX_NS   4000000000

`define NFW_STATUS_RESET   16'h0080
`define NFW_STATUS_READY   16'h0080
`define NFW_STATUS_BUSY    16'h0000

`endif

// *** logic/nfw_ctrl.v ***
/*
 * control-pin front end of a parallel nor flash: bus operation decode,
 * write capture, reset abort timing, deep sleep entry and exit, erase timer.
 * assumes all pins are synchronous to ref_clk and the host keeps its rules.
 */
`timescale 1ns/1ps
`include "nfw_regs.vh"

module nfw_ctrl #(
    parameter AW             = 24,
    parameter DW             = 16,
    parameter RST_BUSY_CYC   = (`NFW_RST_BUSY_NS + `NFW_CLK_NS - 1) / `NFW_CLK_NS,
    parameter SLEEP_LOW_CYC  = (`NFW_SLEEP_LOW_NS + `NFW_CLK_NS - 1) / `NFW_CLK_NS,
    parameter ERASE_CYC      = `NFW_ERASE_TYP_NS / `NFW_CLK_NS
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire          reset_n,
    input  wire          chip_sel_n,
    input  wire          out_en_n,
    input  wire          wr_en_n,
    input  wire          address_valid_n,
    input  wire          deep_sleep_pin,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] data_in,
    input  wire [DW-1:0] rd_word,
    input  wire          sleep_pin_polarity_bit,
    input  wire          sleep_enable_bit,
    input  wire          wait_polarity_bit,
    input  wire          async_read_select_bit,
    input  wire          erase_start,
    input  wire          prog_start,
    input  wire          sync_wait_req,
    output reg  [DW-1:0] data_out,
    output reg  [DW-1:0] data_oe_n,
    output reg           wait_out,
    output reg           wait_oe_n,
    output reg  [2:0]    bus_op,
    output reg           wr_strobe,
    output reg  [AW-1:0] wr_addr,
    output reg  [DW-1:0] wr_data,
    output reg           busy,
    output reg           reset_done,
    output reg           sleep_active,
    output reg           sleep_low_power,
    output reg  [DW-1:0] status
);

    localparam CW = 32;
    localparam RST_IDLE_CYC = (`NFW_RST_IDLE_NS + `NFW_CLK_NS - 1) / `NFW_CLK_NS;
    localparam WR_RD_CYC    = (`NFW_WR_READ_NS + `NFW_ACCESS_NS + `NFW_CLK_NS - 1)
                              / `NFW_CLK_NS;

    // ****************************************
    // bus operation decode
    // ****************************************
    wire       sleep_asserted = deep_sleep_pin ^ ~sleep_pin_polarity_bit;  // RULE19
    wire       sleep_req      = sleep_enable_bit & sleep_asserted;         // RULE21
    wire       wr_active      = ~chip_sel_n & ~wr_en_n;                    // RULE2
    reg  [2:0] op_nxt;

    always @* begin
        if (!reset_n)                           // RULE3
            op_nxt = `NFW_OP_RESET;
        else if (sleep_req && chip_sel_n)       // RULE3
            op_nxt = `NFW_OP_SLEEP;
        else if (chip_sel_n)                    // RULE3
            op_nxt = `NFW_OP_STANDBY;
        else if (!out_en_n && !wr_en_n)         // RULE1
            op_nxt = `NFW_OP_CONFLICT;
        else if (!wr_en_n)                      // RULE2
            op_nxt = `NFW_OP_WRITE;
        else if (!out_en_n)                     // RULE2
            op_nxt = `NFW_OP_READ;
        else                                    // RULE3
            op_nxt = `NFW_OP_OUT_DIS;
    end

    // ****************************************
    // write capture
    // ****************************************
    reg          wr_active_r;
    reg [AW-1:0] wr_addr_hold_r;
    reg [DW-1:0] wr_data_hold_r;
    reg [CW-1:0] wr_rd_cnt_r;
    wire         wr_end = wr_active_r & ~wr_active;  // RULE4

    // run/reset/sleep state and the reset, sleep and erase counters
    localparam S_RUN   = 2'h0;
    localparam S_RESET = 2'h1;
    localparam S_SLEEP = 2'h2;
    reg [1:0]    st_r;
    reg [CW-1:0] rst_cnt_r;
    reg [CW-1:0] sleep_cnt_r;
    reg [CW-1:0] erase_cnt_r;
    reg          op_busy_r;

    always @(posedge ref_clk) begin
        if (rst) begin
            wr_active_r     <= 1'b0;
            wr_addr_hold_r  <= {AW{1'b0}};
            wr_data_hold_r  <= {DW{1'b0}};
            wr_rd_cnt_r     <= {CW{1'b0}};
            wr_strobe       <= 1'b0;
            wr_addr         <= {AW{1'b0}};
            wr_data         <= {DW{1'b0}};
            bus_op          <= `NFW_OP_RESET;
            data_out        <= {DW{1'b0}};
            data_oe_n       <= {DW{1'b1}};
            wait_out        <= 1'b0;
            wait_oe_n       <= 1'b1;
            st_r            <= S_RESET;
            rst_cnt_r       <= {CW{1'b0}};
            sleep_cnt_r     <= {CW{1'b0}};
            erase_cnt_r     <= {CW{1'b0}};
            op_busy_r       <= 1'b0;
            busy            <= 1'b0;
            reset_done      <= 1'b0;
            sleep_active    <= 1'b0;
            sleep_low_power <= 1'b0;
            status          <= `NFW_STATUS_RESET;
        end else begin
            bus_op      <= op_nxt;
            wr_active_r <= wr_active & reset_n & (st_r == S_RUN);
            // track pins while pulse is low; last value before the rise is kept
            if (wr_active) begin
                wr_addr_hold_r <= addr;
                wr_data_hold_r <= data_in;
            end
            wr_strobe <= wr_end & reset_n & (st_r == S_RUN);  // RULE23
            if (wr_end) begin                                  // RULE23
                wr_addr <= wr_addr_hold_r;
                wr_data <= wr_data_hold_r;
            end
            // read data held back after a write
            if (wr_end)
                wr_rd_cnt_r <= WR_RD_CYC;                      // RULE9
            else if (wr_rd_cnt_r != {CW{1'b0}})
                wr_rd_cnt_r <= wr_rd_cnt_r - 1'b1;

            // output drive; z only through enables
            if (op_nxt == `NFW_OP_READ && st_r == S_RUN
                    && wr_rd_cnt_r == {CW{1'b0}}) begin        // RULE9
                data_out  <= rd_word;
                data_oe_n <= {DW{1'b0}};
            end else begin                                     // RULE3
                data_out  <= {DW{1'b0}};
                data_oe_n <= {DW{1'b1}};
            end
            // wait: deasserted level is the inverse of the active polarity
            if (op_nxt == `NFW_OP_READ && st_r == S_RUN) begin
                wait_oe_n <= 1'b0;
                if (async_read_select_bit)                     // RULE20
                    wait_out <= ~wait_polarity_bit;
                else
                    wait_out <= sync_wait_req ~^ wait_polarity_bit;
            end else begin
                wait_out  <= ~wait_polarity_bit;
                wait_oe_n <= 1'b1;
            end

            // erase/program timer
            if (st_r == S_RUN && !op_busy_r && (erase_start || prog_start)) begin
                op_busy_r   <= 1'b1;
                erase_cnt_r <= ERASE_CYC;                      // RULE13
            end else if (op_busy_r && erase_cnt_r != {CW{1'b0}})
                erase_cnt_r <= erase_cnt_r - 1'b1;
            else if (op_busy_r)
                op_busy_r <= 1'b0;

            case (st_r)
                S_RUN: begin
                    reset_done <= 1'b1;
                    if (!reset_n) begin
                        st_r       <= S_RESET;
                        reset_done <= 1'b0;
                        // abort is slow only when an operation is running
                        rst_cnt_r  <= op_busy_r ? RST_BUSY_CYC : RST_IDLE_CYC;  // RULE15
                        op_busy_r  <= 1'b0;
                    end else if (sleep_req && chip_sel_n) begin          // RULE21
                        st_r        <= S_SLEEP;
                        status      <= `NFW_STATUS_RESET;                // RULE22
                        sleep_cnt_r <= SLEEP_LOW_CYC;
                        op_busy_r   <= 1'b0;
                    end
                end
                S_RESET: begin
                    reset_done <= 1'b0;
                    if (rst_cnt_r != {CW{1'b0}})
                        rst_cnt_r <= rst_cnt_r - 1'b1;                   // RULE14
                    else if (reset_n)
                        st_r <= S_RUN;
                end
                S_SLEEP: begin
                    if (sleep_cnt_r != {CW{1'b0}})
                        sleep_cnt_r <= sleep_cnt_r - 1'b1;               // RULE17
                    if (!sleep_req)
                        st_r <= S_RUN;
                end
                default: st_r <= S_RESET;
            endcase

            busy            <= op_busy_r;
            // sleep entry outranks busy: an aborted operation must not leave busy
            if (st_r == S_RUN && reset_n && sleep_req && chip_sel_n)
                status <= `NFW_STATUS_RESET;                             // RULE22
            else if (op_busy_r)
                status <= `NFW_STATUS_BUSY;
            else if (st_r == S_RUN)
                status <= `NFW_STATUS_READY;
            sleep_active    <= (st_r == S_SLEEP);
            sleep_low_power <= (st_r == S_SLEEP) && (sleep_cnt_r == {CW{1'b0}});
        end
    end

endmodule // nfw_ctrl

// *** testbench/nfw_ctrl_assertions.sv ***
/* checker on the ports of nfw_ctrl: decode, write end, sleep.
   assumes ref_clk with sync active-high rst, bound into nfw_ctrl. */
`timescale 1ns/1ps
`include "nfw_regs.vh"
module nfw_ctrl_chk #(
    parameter DW            = 16,
    parameter SLEEP_LOW_CYC = 8
) (
    input wire          ref_clk,
    input wire          rst,
    input wire          reset_n,
    input wire          chip_sel_n,
    input wire          out_en_n,
    input wire          wr_en_n,
    input wire [DW-1:0] data_oe_n,
    input wire [2:0]    bus_op,
    input wire          wr_strobe,
    input wire          reset_done,
    input wire          sleep_active,
    input wire          sleep_low_power,
    input wire [DW-1:0] status
);
    // ****************
    // properties
    // ****************
    localparam int LOW_MAX = SLEEP_LOW_CYC + 4;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_RST_PIN: assert property (!reset_n |=> bus_op == `NFW_OP_RESET && &data_oe_n)
        else $error("reset pin not decoded");
    AST_STANDBY: assert property (reset_n && reset_done && chip_sel_n
        |=> bus_op inside {`NFW_OP_STANDBY, `NFW_OP_SLEEP}) else $error("standby not decoded");
    AST_READ: assert property (reset_n && reset_done && !chip_sel_n && !out_en_n
        && wr_en_n |=> bus_op == `NFW_OP_READ) else $error("read not decoded");
    AST_CONFLICT: assert property (reset_n && reset_done && !out_en_n && !wr_en_n
        && !chip_sel_n |=> bus_op == `NFW_OP_CONFLICT) else $error("conflict not decoded");
    AST_NO_DRIVE: assert property (bus_op != `NFW_OP_READ |-> &data_oe_n)
        else $error("data driven outside read");
    AST_WR_END: assert property (reset_n && reset_done && !$past(chip_sel_n) &&
        !$past(wr_en_n) && out_en_n && $past(out_en_n) && (chip_sel_n || wr_en_n)
        |-> ##[1:3] wr_strobe) else $error("write end not captured");
    AST_STROBE_ONE: assert property (wr_strobe |=> !wr_strobe)
        else $error("write strobe longer than one cycle");
    AST_SLEEP_STATUS: assert property (sleep_active |-> status == `NFW_STATUS_RESET)
        else $error("status not reset in deep sleep");
    AST_SLEEP_LOW: assert property ($rose(sleep_active)
        |-> !sleep_low_power ##[1:LOW_MAX] sleep_low_power) else $error("low power late");
endmodule // nfw_ctrl_chk
bind nfw_ctrl nfw_ctrl_chk #(.DW(DW), .SLEEP_LOW_CYC(SLEEP_LOW_CYC)) u_chk (
    .ref_clk, .rst, .reset_n, .chip_sel_n, .out_en_n, .wr_en_n, .data_oe_n, .bus_op,
    .wr_strobe, .reset_done, .sleep_active, .sleep_low_power, .status);

// *** testbench/nfw_host.sv ***
/* host controller model driving the flash control pins.
   assumes calls from the bench; pins change at the falling edge. */
`timescale 1ns/1ps
module nfw_host (
    input  wire         ref_clk,
    input  wire         pol,
    input  wire         reset_done,
    output logic        reset_n = 1'b1,
    output logic        chip_sel_n = 1'b1,
    output logic        out_en_n = 1'b1,
    output logic        wr_en_n = 1'b1,
    output wire         deep_sleep_pin,
    output logic [23:0] addr = 24'h00_0000,
    output logic [15:0] data_in = 16'h0000
);
    // ****************
    // pin sequences
    // ****************
    logic slp = 1'b0;
    assign deep_sleep_pin = slp ? pol : ~pol;
    task automatic pins(input logic c, input logic o, input logic w);
        @(negedge ref_clk);
        {chip_sel_n, out_en_n, wr_en_n} = {c, o, w};
    endtask
    task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic ce_first);
        @(negedge ref_clk);
        addr = a;
        data_in = d;
        {chip_sel_n, wr_en_n} = 2'b00;
        repeat (2) @(negedge ref_clk);
        if (ce_first) chip_sel_n = 1'b1;
        else wr_en_n = 1'b1;
        @(negedge ref_clk);
        {chip_sel_n, wr_en_n} = 2'b11;
        repeat (4) @(negedge ref_clk);
    endtask
    // counts falling edges from reset low to reset_done
    task automatic rst_pin(input int lo, output int n);
        @(negedge ref_clk);
        reset_n = 1'b0;
        n = 0;
        repeat (lo) @(negedge ref_clk);
        n = lo;
        reset_n = 1'b1;
        while (reset_done !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic sleep(input logic on);
        @(negedge ref_clk);
        slp = on;
        if (!on) repeat (1875) @(negedge ref_clk);
    endtask
endmodule // nfw_host

// *** testbench/tb.sv ***
/* self-checking bench for nfw_ctrl with the host pin model.
   assumes nfw_regs.vh on the include path. */
`timescale 1ns/1ps
`include "nfw_regs.vh"
module tb;
    // ****************
    // bench
    // ****************
    logic        ref_clk = 1'b0, rst = 1'b1, pol = 1'b0, sen = 1'b0;
    logic        wpol = 1'b0, asel = 1'b1, ers = 1'b0, prg = 1'b0, adv_n = 1'b1, swr = 1'b0;
    logic [15:0] rd_word = 16'ha5c3;
    logic [2:0]  ctl [4] = '{3'b111, 3'b011, 3'b001, 3'b000};
    logic [2:0]  eop [4] = '{`NFW_OP_STANDBY, `NFW_OP_OUT_DIS, `NFW_OP_READ, `NFW_OP_CONFLICT};
    wire         reset_n, chip_sel_n, out_en_n, wr_en_n, deep_sleep_pin, wait_out, wait_oe_n;
    wire         wr_strobe, busy, reset_done, sleep_active, sleep_low_power;
    wire  [23:0] addr, wr_addr;
    wire  [15:0] data_in, data_out, data_oe_n, wr_data, status;
    wire  [2:0]  bus_op;
    int          fails = 0, comparisons = 0, cyc = 0, nstb = 0, n;
    nfw_ctrl #(.RST_BUSY_CYC(20), .SLEEP_LOW_CYC(8), .ERASE_CYC(40)) DUT (
        .ref_clk, .rst, .reset_n, .chip_sel_n, .out_en_n, .wr_en_n, .address_valid_n(adv_n),
        .deep_sleep_pin, .addr, .data_in, .rd_word, .sleep_pin_polarity_bit(pol),
        .sleep_enable_bit(sen), .wait_polarity_bit(wpol), .async_read_select_bit(asel),
        .erase_start(ers), .prog_start(prg), .sync_wait_req(swr), .data_out, .data_oe_n,
        .wait_out, .wait_oe_n, .bus_op, .wr_strobe, .wr_addr, .wr_data, .busy, .reset_done,
        .sleep_active, .sleep_low_power, .status);
    nfw_host host (.ref_clk, .pol, .reset_done, .reset_n, .chip_sel_n, .out_en_n, .wr_en_n,
        .deep_sleep_pin, .addr, .data_in);
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (wr_strobe === 1'b1) nstb <= nstb + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            results();
        end
    end
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic kick(input logic p);
        @(negedge ref_clk);
        {prg, ers} = {p, ~p};
        @(negedge ref_clk);
        {prg, ers} = 2'b00;
    endtask
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("status", `NFW_STATUS_RESET, status);
        chk("reset_done", 1'b1, reset_done);
        host.wr(24'h12_3456, 16'hbeef, 1'b0);
        chk("wr_addr", 24'h12_3456, wr_addr);
        chk("wr_data", 16'hbeef, wr_data);
        host.wr(24'hab_cdef, 16'h1234, 1'b1);
        chk("wr_addr", 24'hab_cdef, wr_addr);
        chk("strobes", 24'h00_0002, nstb[23:0]);
        adv_n = 1'b0;
        rd_word = 16'h5a3c;
        host.pins(1'b0, 1'b1, 1'b0);
        adv_n = 1'b1;
        host.pins(1'b0, 1'b1, 1'b1);
        host.pins(1'b0, 1'b0, 1'b1);
        @(negedge ref_clk);
        chk("rd_hold", 16'hffff, data_oe_n);
        repeat (2) @(negedge ref_clk);
        chk("rd_hold", 16'hffff, data_oe_n);
        repeat (2) @(negedge ref_clk);
        chk("rd_drive", 16'h0000, data_oe_n);
        chk("data_out", 16'h5a3c, data_out);
        chk("strobes", 24'h00_0003, nstb[23:0]);
        host.pins(1'b1, 1'b1, 1'b1);
        $display("test writes done");
        for (int i = 0; i < 4; i++) begin
            wpol = i[0];
            host.pins(ctl[i][2], ctl[i][1], ctl[i][0]);
            repeat (6) @(negedge ref_clk);
            chk("bus_op", eop[i], bus_op);
            chk("data_oe_n", i == 2 ? 16'h0000 : 16'hffff, data_oe_n);
            if (i == 2) chk("data_out", rd_word, data_out);
            if (i == 2) chk("wait_out", !wpol, wait_out);
            chk("wait_oe_n", i == 2 ? 1'b0 : 1'b1, wait_oe_n);
            if (i == 2) begin
                asel = 1'b0;
                swr  = 1'b1;
                repeat (2) @(negedge ref_clk);
                chk("wait_sync", wpol, wait_out);
                swr = 1'b0;
                repeat (2) @(negedge ref_clk);
                chk("wait_sync", !wpol, wait_out);
                asel = 1'b1;
            end
            host.pins(1'b1, 1'b1, 1'b1);
        end
        $display("test decode done");
        for (int k = 0; k < 2; k++) begin
            kick(k[0]);
            repeat (2) @(negedge ref_clk);
            chk("status", `NFW_STATUS_BUSY, status);
            n = 0;
            while (busy !== 1'b0 && n < 100) begin
                @(negedge ref_clk);
                n++;
            end
            chk("op_time", 1'b1, n >= 35 && n <= 42);
        end
        host.rst_pin(3, n);
        chk("idle_reset", 1'b1, n <= 6);
        kick(1'b0);
        host.rst_pin(3, n);
        chk("busy_reset", 1'b1, n >= 20 && n <= 24);
        chk("busy", 1'b0, busy);
        repeat (4) @(negedge ref_clk);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            sen = 1'b0;
            kick(1'b1);
            host.sleep(1'b1);
            repeat (4) @(negedge ref_clk);
            chk("sleep_off", 1'b0, sleep_active);
            sen = 1'b1;
            repeat (3) @(negedge ref_clk);
            chk("sleep_on", 1'b1, sleep_active);
            chk("status", `NFW_STATUS_RESET, status);
            repeat (9) @(negedge ref_clk);
            chk("low_power", 1'b1, sleep_low_power);
            host.sleep(1'b0);
            chk("sleep_exit", 1'b0, sleep_active);
        end
        $display("test sleep done");
        results();
    end
endmodule // tb
